// File: common/acq_ctrl_pkg.sv
// Constants shared by the acquisition control register set
package acq_ctrl_pkg;
	// Register port widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	// Register offsets
	localparam logic [7:0] BAUD_HIGH_ADDR  = 8'h17;
	localparam logic [7:0] BAUD_LOW_ADDR   = 8'h18;
	localparam logic [7:0] RATE_SEL_ADDR   = 8'h19;
	localparam logic [7:0] DEMOD_CTRL_ADDR = 8'h1a;
	localparam logic [7:0] START_ADDR      = 8'h1b;
	// Reset values
	localparam logic [7:0] BAUD_HIGH_RST = 8'h80;
	localparam logic [7:0] BAUD_LOW_RST  = 8'h80;
	localparam logic [7:0] RATE_SEL_RST  = 8'h44;
	localparam logic [7:0] CTRL_RST      = 8'h00;
	// Field positions and widths
	localparam int BAUD_SEARCH_BIT = 15;
	localparam int BAUD_RSVD_BIT   = 14;
	localparam int BAUD_RATE_W     = 14;
	localparam int SUBRANGE_N      = 12;
	localparam int CODE_RATE_N     = 6;
	localparam int RATE_AUTO_BIT   = 7;
	localparam int RATE_SWAP_BIT   = 6;
	localparam int CTRL_FRONT_BIT  = 6;
	localparam int CTRL_AFC_BIT    = 2;
	localparam int CTRL_ROLL_BIT   = 0;
	localparam int START_BIT       = 0;
	// Only these control bits are stored; the rest read as zero
	localparam logic [7:0] CTRL_WR_MASK = 8'h45;
	// Fixed-format symbol rate, megabaud times the scale
	localparam int DSS_MBAUD  = 20;
	localparam int BAUD_SCALE = 256;
	localparam logic [13:0] DSS_BAUD = 14'(DSS_MBAUD * BAUD_SCALE);
	// Clock divisors bounding the sub-ranges; entry k bounds bit 11-k
	localparam logic [12:0][7:0] SWEEP_DIV = {8'h80, 8'h60, 8'h40, 8'h30,
		8'h20, 8'h18, 8'h10, 8'h0c, 8'h08, 8'h06, 8'h04, 8'h03, 8'h02};
endpackage

// File: common/acq_cfg_if.sv
// Carrier between the register set and its two sequencers
`timescale 1ns/10ps
interface acq_cfg_if;
	logic        start;       // Capture start pulse
	logic        dss;         // Fixed-format override active
	logic        search_en;   // Baud search mode selected
	logic [11:0] sub_mask;    // Sub-ranges selected for sweep
	logic        sub_done;    // Datapath finished a sub-range
	logic [3:0]  sub_idx;     // Sub-range under sweep
	logic [7:0]  div_fast;    // Divisor of the fast bound
	logic [7:0]  div_slow;    // Divisor of the slow bound
	logic        sweeping;    // Sweep in progress
	logic [5:0]  rate_mask;   // Code rates selected
	logic [2:0]  start_rate;  // First code rate to try
	logic        auto_phase;  // Automatic phase resolution
	logic        phase_init;  // Programmed decoder phase
	logic        rate_fail;   // No signal at current trial
	logic        fec_lock;    // Decoder locked at current trial
	logic [2:0]  cur_rate;    // Code rate under trial or found
	logic        trial_phase; // Phase under trial or found
	logic        locked;      // Search ended in lock
	logic        wb_valid;    // Phase write-back pulse
	logic        wb_phase;    // Phase to write back
	modport ctrl (output start, dss, search_en, sub_mask, sub_done, rate_mask, start_rate,
		auto_phase, phase_init, rate_fail, fec_lock,
		input sub_idx, div_fast, div_slow, sweeping, cur_rate, trial_phase, locked,
		wb_valid, wb_phase);
	modport sweep (input start, dss, search_en, sub_mask, sub_done,
		output sub_idx, div_fast, div_slow, sweeping);
	modport search (input start, dss, rate_mask, start_rate, auto_phase, phase_init,
		rate_fail, fec_lock,
		output cur_rate, trial_phase, locked, wb_valid, wb_phase);
endinterface

// File: hw/baud_sweep.sv
// Symbol-rate sub-range sweep sequencer
`timescale 1ns/10ps
module baud_sweep
	import acq_ctrl_pkg::*;
(
	input  wire logic system_clock_i, // System clock
	input  wire logic arst_n_i,  // Asynchronous reset, active low
	acq_cfg_if.sweep  cfg        // Shared configuration
);
	typedef enum logic {SW_IDLE, SW_RUN} sweep_state_e;
	typedef struct packed {
		sweep_state_e st;   // Sweep state
		logic [3:0]   idx;  // Current sub-range
		logic [7:0]   fast; // Fast bound divisor
		logic [7:0]   slow; // Slow bound divisor
	} sweep_s;
	sweep_s q;      // Registered state
	sweep_s next_q; // Next state

	// Nearest selected sub-range below from, wrapping to the top
	function automatic logic [3:0] next_sub(input logic [11:0] m, input logic [3:0] from);
		logic [3:0] r;
		int k;
		r = from;
		for (int n = SUBRANGE_N; n >= 1; n--) begin
			k = (int'(from) - n + SUBRANGE_N) % SUBRANGE_N;
			if (m[k]) begin
				r = 4'(k);
			end
		end
		return r;
	endfunction

	// Unselected sub-ranges are skipped, so a sweep never visits them
	always_comb begin
		next_q = q;
		if (cfg.start) begin
			// Sweep only runs in search mode without the fixed-format override
			if (cfg.search_en && !cfg.dss && (|cfg.sub_mask)) begin
				next_q.st  = SW_RUN;
				next_q.idx = next_sub(cfg.sub_mask, 4'h0);
			end else begin
				next_q.st = SW_IDLE;
			end
		end else if (q.st == SW_RUN) begin
			if (!cfg.search_en || cfg.dss || !(|cfg.sub_mask)) begin
				next_q.st = SW_IDLE;
			end else if (cfg.sub_done) begin
				next_q.idx = next_sub(cfg.sub_mask, q.idx);
			end
		end
		// Bit 11 spans clock/2 to /3, each lower bit a slower span
		next_q.fast = SWEEP_DIV[4'(SUBRANGE_N - 1) - next_q.idx];
		next_q.slow = SWEEP_DIV[4'(SUBRANGE_N) - next_q.idx];
	end

	// State register
	always_ff @(posedge system_clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			q <= '{st: SW_IDLE, idx: 4'hb, fast: 8'h02, slow: 8'h03};
		end else begin
			q <= next_q;
		end
	end

	assign cfg.sub_idx  = q.idx;
	assign cfg.div_fast = q.fast;
	assign cfg.div_slow = q.slow;
	assign cfg.sweeping = (q.st == SW_RUN);
endmodule

// File: hw/rate_search.sv
// Code-rate and decoder phase search sequencer
`timescale 1ns/10ps
module rate_search
	import acq_ctrl_pkg::*;
#(
	parameter logic [5:0] DSS_RATE_MASK = 6'h3f // Rates tried under the override
)(
	input  wire logic system_clock_i, // System clock
	input  wire logic arst_n_i,  // Asynchronous reset, active low
	acq_cfg_if.search cfg        // Shared configuration
);
	typedef enum logic [1:0] {RS_IDLE, RS_TRY, RS_LOCK} search_state_e;
	typedef struct packed {
		search_state_e st;  // Search state
		logic [2:0]    cur; // Rate under trial
		logic          ph;  // Phase under trial
		logic          alt; // Second phase already tried
		logic          lck; // Search ended in lock
		logic          wbv; // Write-back pulse
		logic          wbp; // Write-back phase
	} search_s;
	search_s    q;      // Registered state
	search_s    next_q; // Next state
	logic [5:0] mask;   // Rates in play
	logic [2:0] first;  // Legal starting rate

	// Nearest selected rate above from (or at it when incl), wrapping
	function automatic logic [2:0] next_rate(input logic [5:0] m, input logic [2:0] from,
		input logic incl);
		logic [2:0] r;
		int k;
		r = from;
		for (int n = CODE_RATE_N; n >= 1; n--) begin
			k = (int'(from) + n - (incl ? 1 : 0)) % CODE_RATE_N;
			if (m[k]) begin
				r = 3'(k);
			end
		end
		return r;
	endfunction

	// Trial order: each rate at the start phase, then the other phase if automatic
	always_comb begin
		next_q = q;
		next_q.wbv = 1'b0;
		mask = cfg.dss ? DSS_RATE_MASK : cfg.rate_mask;
		first = (cfg.start_rate > 3'(CODE_RATE_N - 1)) ? 3'h0 : cfg.start_rate;
		if (cfg.start) begin
			next_q.lck = 1'b0;
			next_q.alt = 1'b0;
			next_q.ph  = cfg.phase_init;
			if (|mask) begin
				next_q.st  = RS_TRY;
				next_q.cur = next_rate(mask, first, 1'b1);
			end else begin
				next_q.st = RS_IDLE;
			end
		end else begin
			case (q.st)
				RS_TRY: begin
					if (cfg.fec_lock) begin
						next_q.st  = RS_LOCK;
						next_q.lck = 1'b1;
						next_q.wbv = cfg.auto_phase;
						next_q.wbp = q.ph;
					end else if (cfg.rate_fail) begin
						if (cfg.auto_phase && !q.alt) begin
							next_q.ph  = ~q.ph;
							next_q.alt = 1'b1;
						end else begin
							next_q.alt = 1'b0;
							next_q.ph  = cfg.phase_init;
							next_q.cur = next_rate(mask, q.cur, 1'b0);
						end
					end
				end
				RS_LOCK: begin
					next_q.st = RS_LOCK; // Hold the result until the next start
				end
				default: begin
					next_q.st = RS_IDLE;
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge system_clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			q <= '{st: RS_IDLE, cur: 3'h0, ph: 1'b0, alt: 1'b0, lck: 1'b0, wbv: 1'b0,
				wbp: 1'b0};
		end else begin
			q <= next_q;
		end
	end

	assign cfg.cur_rate    = q.cur;
	assign cfg.trial_phase = q.ph;
	assign cfg.locked      = q.lck;
	assign cfg.wb_valid    = q.wbv;
	assign cfg.wb_phase    = q.wbp;
endmodule

// File: hw/acq_ctrl_regs.sv
// Demodulator acquisition control register set
//
// Functional notes
// - Top two baud bits zero: known rate
// - Low fourteen bits are megabaud times 256
// - Top bit set selects sub-range search mode
// - Sweep only selected sub-ranges, bit 11 fastest
// - Fixed-format override forces twenty megabaud
// - Auto phase: search, then write phase back
// - Manual phase: decoder swap used as written
// - Decoder swap exchanges decoder I and Q
// - Search only the selected code rates
// - Start at set rate, advance to higher
// - Override ignores the selected code rates
// - Report code-rate search outcome as status
// - Front swap exchanges I and Q early
// - Tracking mode bit enables AFC tracking
// - Roll-off 0.20 when set, else 0.35
// - Override forces roll-off to 0.20
// - Start bit launches capture, self-clears
// - Start register always reads zero
`timescale 1ns/10ps
module acq_ctrl_regs
	import acq_ctrl_pkg::*;
(
	input  wire logic              system_clock_i,          // System clock, 250 MHz
	input  wire logic              arst_n_i,           // Asynchronous reset, active low
	input  wire logic [ADDR_W-1:0] reg_addr_i,         // Register address
	input  wire logic [DATA_W-1:0] reg_wdata_i,        // Write data
	input  wire logic              reg_wr_i,           // Write strobe
	input  wire logic              reg_rd_i,           // Read strobe
	output logic      [DATA_W-1:0] reg_rdata_o,        // Read data
	output logic                   reg_rvalid_o,       // Read data valid
	input  wire logic [1:0]        dss_sel_i,          // Fixed-format configuration bits
	input  wire logic [2:0]        setup_start_rate_i, // Starting code rate
	input  wire logic              subrange_done_i,    // Sub-range sweep finished
	input  wire logic              rate_fail_i,        // No signal at current trial
	input  wire logic              fec_lock_i,         // Decoder lock at current trial
	output logic                   acq_start_o,        // Capture start pulse
	output logic                   known_rate_o,       // Known-rate mode
	output logic                   search_mode_o,      // Sub-range search mode
	output logic      [13:0]       baud_value_o,       // Rate, megabaud times scale
	output logic      [3:0]        subrange_idx_o,     // Sub-range under sweep
	output logic      [7:0]        sweep_div_fast_o,   // Divisor of the fast bound
	output logic      [7:0]        sweep_div_slow_o,   // Divisor of the slow bound
	output logic                   sweep_active_o,     // Sweep running
	output logic      [2:0]        code_rate_o,        // Code rate tried or found
	output logic                   rate_locked_o,      // Code-rate search locked
	output logic                   decoder_iq_swap_o,  // Swap I and Q to the decoder
	output logic                   front_iq_swap_o,    // Swap I and Q before demodulation
	output logic                   afc_mode_o,         // AFC tracking mode
	output logic                   rolloff_20_o        // Roll-off 0.20 when high
);
	typedef struct packed {
		logic [7:0]  baud_hi;   // baud_setting_high
		logic [7:0]  baud_lo;   // baud_setting_low
		logic [7:0]  rate_sel;  // decoder_rate_select
		logic [7:0]  ctrl;      // demod_control
		logic        start_p;   // Capture start pulse
		logic [7:0]  rdata;     // Read data
		logic        rvalid;    // Read data valid
		logic        known;     // Known-rate mode
		logic        search;    // Search mode
		logic [13:0] baud_val;  // Effective rate
		logic        front;     // Front-end swap
		logic        afc;       // AFC tracking
		logic        roll20;    // Roll-off 0.20
		logic        dec_swap;  // Decoder swap in use
	} regs_s;
	regs_s       q;       // Registered state
	regs_s       next_q;  // Next state
	logic [15:0] baud;    // Full baud_setting pair after this cycle's write
	logic        dss;     // Fixed-format override

	acq_cfg_if cfg_bus (); // Link to the sequencers

	// Sub-range sweep
	baud_sweep u_sweep (
		.system_clock_i (system_clock_i),
		.arst_n_i  (arst_n_i),
		.cfg       (cfg_bus.sweep)
	);

	// Code-rate and phase search
	rate_search u_search (
		.system_clock_i (system_clock_i),
		.arst_n_i  (arst_n_i),
		.cfg       (cfg_bus.search)
	);

	assign dss = |dss_sel_i; // Either bit enables the override

	// Register writes, reads and field decode
	always_comb begin
		next_q = q;
		next_q.start_p = 1'b0;
		next_q.rvalid = reg_rd_i;
		baud = 16'h0000;
		// Software writes
		if (reg_wr_i) begin
			case (reg_addr_i)
				BAUD_HIGH_ADDR: begin
					// Bit 14 is stored as written; decode never looks at it
					next_q.baud_hi = reg_wdata_i;
				end
				BAUD_LOW_ADDR: begin
					next_q.baud_lo = reg_wdata_i;
				end
				RATE_SEL_ADDR: begin
					next_q.rate_sel = reg_wdata_i;
				end
				DEMOD_CTRL_ADDR: begin
					// Reserved bits dropped so stray writes cannot steer anything
					next_q.ctrl = reg_wdata_i & CTRL_WR_MASK;
				end
				START_ADDR: begin
					// Writing zero does nothing; the pulse clears itself
					next_q.start_p = reg_wdata_i[START_BIT];
				end
				default: begin
					next_q.ctrl = next_q.ctrl; // Unmapped: ignored
				end
			endcase
		end
		// Found phase wins over a software write in the same cycle
		if (cfg_bus.wb_valid) begin
			next_q.rate_sel[RATE_SWAP_BIT] = cfg_bus.wb_phase;
		end
		// Reads return contents before this cycle's write
		if (reg_rd_i) begin
			case (reg_addr_i)
				BAUD_HIGH_ADDR: begin
					next_q.rdata = q.baud_hi;
				end
				BAUD_LOW_ADDR: begin
					next_q.rdata = q.baud_lo;
				end
				RATE_SEL_ADDR: begin
					next_q.rdata = q.rate_sel;
				end
				DEMOD_CTRL_ADDR: begin
					next_q.rdata = q.ctrl;
				end
				START_ADDR: begin
					next_q.rdata = 8'h00;
				end
				default: begin
					next_q.rdata = 8'h00; // Unmapped reads zero
				end
			endcase
		end
		// Mode decode follows the registers after this cycle's write
		baud = {next_q.baud_hi, next_q.baud_lo};
		// Bit 15 alone picks search; bit 14 is reserved, so 01 stays known-rate
		next_q.search = !dss && baud[BAUD_SEARCH_BIT];
		next_q.known = !dss && !baud[BAUD_SEARCH_BIT];
		if (dss) begin
			next_q.baud_val = DSS_BAUD;
		end else begin
			next_q.baud_val = baud[BAUD_RATE_W-1:0];
		end
		next_q.front = next_q.ctrl[CTRL_FRONT_BIT];
		next_q.afc = next_q.ctrl[CTRL_AFC_BIT];
		next_q.roll20 = dss || next_q.ctrl[CTRL_ROLL_BIT];
		// Auto mode shows the phase under trial, manual mode the bit itself
		if (next_q.rate_sel[RATE_AUTO_BIT]) begin
			next_q.dec_swap = cfg_bus.trial_phase;
		end else begin
			next_q.dec_swap = next_q.rate_sel[RATE_SWAP_BIT];
		end
	end

	// State register
	always_ff @(posedge system_clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			q <= '{baud_hi: BAUD_HIGH_RST, baud_lo: BAUD_LOW_RST, rate_sel: RATE_SEL_RST,
				ctrl: CTRL_RST, start_p: 1'b0, rdata: 8'h00, rvalid: 1'b0, known: 1'b0,
				search: 1'b1, baud_val: 14'h0080, front: 1'b0, afc: 1'b0, roll20: 1'b0,
				dec_swap: 1'b1};
		end else begin
			q <= next_q;
		end
	end

	// Configuration toward the sequencers
	assign cfg_bus.start      = q.start_p;
	assign cfg_bus.dss        = dss;
	assign cfg_bus.search_en  = q.search;
	assign cfg_bus.sub_mask   = {q.baud_hi[3:0], q.baud_lo};
	assign cfg_bus.sub_done   = subrange_done_i;
	assign cfg_bus.rate_mask  = q.rate_sel[CODE_RATE_N-1:0];
	assign cfg_bus.start_rate = setup_start_rate_i;
	assign cfg_bus.auto_phase = q.rate_sel[RATE_AUTO_BIT];
	assign cfg_bus.phase_init = q.rate_sel[RATE_SWAP_BIT];
	assign cfg_bus.rate_fail  = rate_fail_i;
	assign cfg_bus.fec_lock   = fec_lock_i;

	// Outputs, each straight from a flip-flop here or in a sequencer
	assign reg_rdata_o       = q.rdata;
	assign reg_rvalid_o      = q.rvalid;
	assign acq_start_o       = q.start_p;
	assign known_rate_o      = q.known;
	assign search_mode_o     = q.search;
	assign baud_value_o      = q.baud_val;
	assign subrange_idx_o    = cfg_bus.sub_idx;
	assign sweep_div_fast_o  = cfg_bus.div_fast;
	assign sweep_div_slow_o  = cfg_bus.div_slow;
	assign sweep_active_o    = cfg_bus.sweeping;
	assign code_rate_o       = cfg_bus.cur_rate;
	assign rate_locked_o     = cfg_bus.locked;
	assign decoder_iq_swap_o = q.dec_swap;
	assign front_iq_swap_o   = q.front;
	assign afc_mode_o        = q.afc;
	assign rolloff_20_o      = q.roll20;
endmodule

// File: testbench/acq_ctrl_regs_monitor.sv
// Port-level assertions for the acquisition control register set
`timescale 1ns/10ps
module acq_ctrl_regs_monitor
	import acq_ctrl_pkg::*;
(
	input wire logic              system_clock_i,
	input wire logic              arst_n_i,
	input wire logic [ADDR_W-1:0] reg_addr_i,
	input wire logic [DATA_W-1:0] reg_wdata_i,
	input wire logic              reg_wr_i,
	input wire logic              reg_rd_i,
	input wire logic [DATA_W-1:0] reg_rdata_o,
	input wire logic              reg_rvalid_o,
	input wire logic [1:0]        dss_sel_i,
	input wire logic [2:0]        setup_start_rate_i,
	input wire logic              subrange_done_i,
	input wire logic              rate_fail_i,
	input wire logic              fec_lock_i,
	input wire logic              acq_start_o,
	input wire logic              known_rate_o,
	input wire logic              search_mode_o,
	input wire logic [13:0]       baud_value_o,
	input wire logic [3:0]        subrange_idx_o,
	input wire logic [7:0]        sweep_div_fast_o,
	input wire logic [7:0]        sweep_div_slow_o,
	input wire logic              sweep_active_o,
	input wire logic [2:0]        code_rate_o,
	input wire logic              rate_locked_o,
	input wire logic              decoder_iq_swap_o,
	input wire logic              front_iq_swap_o,
	input wire logic              afc_mode_o,
	input wire logic              rolloff_20_o
);
	// One clock domain, so clock and reset are given once
	default clocking cb @(posedge system_clock_i);
	endclocking
	default disable iff (!arst_n_i);

	// A start write with bit 0 set gives the capture pulse next cycle
	chk_start_pulse: assert property (reg_wr_i && reg_addr_i == START_ADDR
		&& reg_wdata_i[0] |=> acq_start_o) else $error("start write gave no pulse");
	// Pulse lasts exactly one cycle
	chk_start_single: assert property (acq_start_o |=> !acq_start_o)
		else $error("start pulse too long");
	// No pulse without a start write carrying a one
	chk_start_cause: assert property (!(reg_wr_i && reg_addr_i == START_ADDR
		&& reg_wdata_i[0]) |=> !acq_start_o) else $error("start pulse without cause");
	// Start register and unmapped places above it read as zero
	chk_start_reads: assert property (reg_rd_i && reg_addr_i >= START_ADDR
		|=> reg_rvalid_o && reg_rdata_o == 8'h00) else $error("start read not zero");
	// Read answer comes one cycle after the strobe, never otherwise
	chk_rvalid_timing: assert property (reg_rvalid_o == $past(reg_rd_i))
		else $error("read valid misplaced");
	// Override forces twenty megabaud and neither rate mode
	chk_dss_baud: assert property (dss_sel_i != 2'b00 |=> baud_value_o == DSS_BAUD
		&& !known_rate_o && !search_mode_o) else $error("override rate wrong");
	// Override forces the 0.20 roll-off
	chk_dss_rolloff: assert property (dss_sel_i != 2'b00 |=> rolloff_20_o)
		else $error("override roll-off wrong");
	// Top bits 00 written without override selects known rate
	chk_known_mode: assert property (reg_wr_i && reg_addr_i == BAUD_HIGH_ADDR
		&& reg_wdata_i[7:6] == 2'b00 && dss_sel_i == 2'b00
		|-> ##[1:2] known_rate_o && !search_mode_o) else $error("known rate not taken");
	// Top bit set without override selects search mode
	chk_search_mode: assert property (reg_wr_i && reg_addr_i == BAUD_HIGH_ADDR
		&& reg_wdata_i[7] && dss_sel_i == 2'b00
		|-> ##[1:2] search_mode_o && !known_rate_o) else $error("search mode not taken");
endmodule

bind acq_ctrl_regs acq_ctrl_regs_monitor i_acq_ctrl_regs_monitor (
	.system_clock_i(system_clock_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .dss_sel_i(dss_sel_i),
	.setup_start_rate_i(setup_start_rate_i), .subrange_done_i(subrange_done_i),
	.rate_fail_i(rate_fail_i), .fec_lock_i(fec_lock_i), .acq_start_o(acq_start_o),
	.known_rate_o(known_rate_o), .search_mode_o(search_mode_o),
	.baud_value_o(baud_value_o), .subrange_idx_o(subrange_idx_o),
	.sweep_div_fast_o(sweep_div_fast_o), .sweep_div_slow_o(sweep_div_slow_o),
	.sweep_active_o(sweep_active_o), .code_rate_o(code_rate_o),
	.rate_locked_o(rate_locked_o), .decoder_iq_swap_o(decoder_iq_swap_o),
	.front_iq_swap_o(front_iq_swap_o), .afc_mode_o(afc_mode_o), .rolloff_20_o(rolloff_20_o));

// File: testbench/demod_acquisition_control_tb.sv
// Self-checking bench for the acquisition control register set
`timescale 1ns/10ps
module demod_acquisition_control_tb
	import acq_ctrl_pkg::*;
;
	logic        system_clock_i = 1'b0;          // 250 MHz system clock
	logic        arst_n_i = 1'b0;           // Reset held from time zero
	logic [7:0]  reg_addr_i = 8'h00;        // Register address
	logic [7:0]  reg_wdata_i = 8'h00;       // Write data
	logic        reg_wr_i = 1'b0;           // Write strobe
	logic        reg_rd_i = 1'b0;           // Read strobe
	logic [1:0]  dss_sel_i = 2'b00;         // Override bits
	logic [2:0]  setup_start_rate_i = 3'h0; // First code rate
	logic [2:0]  ev = 3'h0;                 // Done, fail, lock pulses
	logic [7:0]  reg_rdata_o;
	logic        reg_rvalid_o, acq_start_o, known_rate_o, search_mode_o, sweep_active_o;
	logic [13:0] baud_value_o;
	logic [3:0]  subrange_idx_o;
	logic [7:0]  sweep_div_fast_o, sweep_div_slow_o, d;
	logic [2:0]  code_rate_o;
	logic        rate_locked_o, decoder_iq_swap_o, front_iq_swap_o, afc_mode_o, rolloff_20_o;
	int          err_count = 0;              // Mismatches
	int          n_checks = 0;               // Comparisons made
	int          cyc = 0;                    // Cycles run, for the hang guard
	logic [7:0]  rd_q[$];                    // Expected read data, oldest first
	logic [31:0] seed = 32'h9436;            // Random source state
	logic [7:0]  rst_v[5] = '{8'h80, 8'h80, 8'h44, 8'h00, 8'h00}; // Reset table

	acq_ctrl_regs i_acq_ctrl_regs (
		.system_clock_i(system_clock_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .dss_sel_i(dss_sel_i),
		.setup_start_rate_i(setup_start_rate_i), .subrange_done_i(ev[2]),
		.rate_fail_i(ev[1]), .fec_lock_i(ev[0]), .acq_start_o(acq_start_o),
		.known_rate_o(known_rate_o), .search_mode_o(search_mode_o),
		.baud_value_o(baud_value_o), .subrange_idx_o(subrange_idx_o),
		.sweep_div_fast_o(sweep_div_fast_o), .sweep_div_slow_o(sweep_div_slow_o),
		.sweep_active_o(sweep_active_o), .code_rate_o(code_rate_o),
		.rate_locked_o(rate_locked_o), .decoder_iq_swap_o(decoder_iq_swap_o),
		.front_iq_swap_o(front_iq_swap_o), .afc_mode_o(afc_mode_o), .rolloff_20_o(rolloff_20_o));

	// Clock, 4 ns period
	always #2 system_clock_i = ~system_clock_i;

	// Next value of the random source
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Verdict and end of run
	task automatic conclude;
		$display("Checks %0d, mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Compare one result, case equality so unknowns fail
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One write cycle, driven just after the edge
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge system_clock_i);
		#1;
		reg_wr_i = 1'b1;
		reg_addr_i = a;
		reg_wdata_i = v;
		@(posedge system_clock_i);
		#1;
		reg_wr_i = 1'b0;
	endtask

	// One read cycle; the answer is judged by the watcher below
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge system_clock_i);
		#1;
		reg_rd_i = 1'b1;
		reg_addr_i = a;
		rd_q.push_back(e);
		@(posedge system_clock_i);
		#1;
		reg_rd_i = 1'b0;
	endtask

	// One-cycle datapath event, then time for the outputs to follow
	task automatic pulse(input logic [2:0] p);
		@(posedge system_clock_i);
		#1;
		ev = p;
		@(posedge system_clock_i);
		#1;
		ev = 3'h0;
		repeat (2) @(posedge system_clock_i);
		#1;
	endtask

	// Let registered outputs follow a write
	task automatic settle;
		repeat (2) @(posedge system_clock_i);
		#1;
	endtask

	// Read watcher on the falling edge, where the answer is settled
	always @(negedge system_clock_i) begin
		if (reg_rvalid_o === 1'b1) begin
			if (rd_q.size() == 0)
				chk(24'(reg_rdata_o), 24'hffffff);
			else
				chk(24'(reg_rdata_o), 24'(rd_q.pop_front()));
		end
	end

	// Hang guard: the whole run needs well under 2000 cycles
	always @(posedge system_clock_i) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			$display("Error at %0t: timeout", $time);
			conclude();
		end
	end

	initial begin
		repeat (6) @(posedge system_clock_i);
		#1;
		arst_n_i = 1'b1;
		// Reset values at the ports and in the registers
		chk({known_rate_o, search_mode_o, acq_start_o, sweep_active_o}, 4'b0100);
		chk(baud_value_o, 14'h0080);
		chk({subrange_idx_o, sweep_div_fast_o, sweep_div_slow_o}, 20'hb0203);
		chk({decoder_iq_swap_o, rolloff_20_o, rate_locked_o}, 3'b100);
		for (int i = 0; i < 5; i++)
			rd(8'h17 + 8'(i), rst_v[i]);
		rd(8'h20, 8'h00);
		$display("Test reset done");
		// Known rate 7.5 megabaud, slow enough for AFC tracking
		wr(BAUD_HIGH_ADDR, 8'h07);
		wr(BAUD_LOW_ADDR, 8'h80);
		settle();
		chk({known_rate_o, search_mode_o}, 2'b10);
		chk(baud_value_o, 14'h0780);
		rd(BAUD_HIGH_ADDR, 8'h07);
		$display("Test known rate done");
		// Random control settings, reserved bits kept low
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			d = seed[7:0] & CTRL_WR_MASK;
			wr(DEMOD_CTRL_ADDR, d);
			settle();
			chk({front_iq_swap_o, afc_mode_o, rolloff_20_o}, {d[6], d[2], d[0]});
			rd(DEMOD_CTRL_ADDR, d);
		end
		wr(DEMOD_CTRL_ADDR, 8'h00);
		$display("Test control done");
		// Each override setting
		for (int s = 1; s < 4; s++) begin
			dss_sel_i = 2'(s);
			settle();
			chk({baud_value_o, known_rate_o, search_mode_o, rolloff_20_o},
				{DSS_BAUD, 3'b001});
		end
		dss_sel_i = 2'b00;
		settle();
		chk({baud_value_o, rolloff_20_o}, {14'h0780, 1'b0});
		$display("Test override done");
		// Start command: zero does nothing, one pulses once
		wr(START_ADDR, 8'h00);
		chk(acq_start_o, 1'b0);
		wr(START_ADDR, 8'h01);
		chk(acq_start_o, 1'b1);
		@(posedge system_clock_i);
		#1;
		chk(acq_start_o, 1'b0);
		rd(START_ADDR, 8'h00);
		$display("Test start done");
		// Sweep of sub-ranges 11 and 0 only, wrapping
		wr(BAUD_HIGH_ADDR, 8'h88);
		wr(BAUD_LOW_ADDR, 8'h01);
		wr(START_ADDR, 8'h01);
		settle();
		chk({sweep_active_o, subrange_idx_o, sweep_div_fast_o, sweep_div_slow_o},
			21'h1b0203);
		pulse(3'b100);
		chk({subrange_idx_o, sweep_div_fast_o, sweep_div_slow_o}, 20'h06080);
		pulse(3'b100);
		chk(subrange_idx_o, 4'hb);
		wr(BAUD_HIGH_ADDR, 8'h1b);
		$display("Test sweep done");
		// Manual phase, rates 2/3 and 5/6, start at 3/4
		setup_start_rate_i = 3'd2;
		wr(RATE_SEL_ADDR, 8'h4a);
		wr(START_ADDR, 8'h01);
		settle();
		chk({code_rate_o, decoder_iq_swap_o, rate_locked_o}, {3'd3, 2'b10});
		pulse(3'b010);
		chk({code_rate_o, decoder_iq_swap_o}, {3'd1, 1'b1});
		pulse(3'b001);
		chk(rate_locked_o, 1'b1);
		$display("Test manual rate done");
		// Automatic phase: fail flips phase, lock writes it back
		setup_start_rate_i = 3'd0;
		wr(RATE_SEL_ADDR, 8'h84);
		wr(START_ADDR, 8'h01);
		settle();
		chk({code_rate_o, decoder_iq_swap_o, rate_locked_o}, {3'd2, 2'b00});
		pulse(3'b010);
		chk({code_rate_o, decoder_iq_swap_o}, {3'd2, 1'b1});
		pulse(3'b001);
		chk(rate_locked_o, 1'b1);
		rd(RATE_SEL_ADDR, 8'hc4);
		$display("Test auto phase done");
		// Override ignores the selected code rates
		dss_sel_i = 2'b01;
		wr(RATE_SEL_ADDR, 8'h08);
		wr(START_ADDR, 8'h01);
		settle();
		chk(code_rate_o, 3'd0);
		dss_sel_i = 2'b00;
		settle();
		chk(24'(rd_q.size()), 24'h000000);
		$display("Test override rates done");
		conclude();
	end
endmodule
